// >>> hdl/sbg_pkg.sv
// Package: register map, field positions and rate constants of the baud generator
package sbg_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_TRANSMIT_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RECEIVE_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_DIVISOR_HIGH_BYTE = 8'h0C;
  localparam logic [7:0] ADDR_DIVISOR_LOW_BYTE = 8'h10;
  localparam logic [7:0] ADDR_GENERATOR_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int TXSC_SYNC_BIT = 4;
  localparam int TXSC_HIGH_SPEED_BIT = 2;
  localparam int BAUD_WIDE_DIVISOR_BIT = 3;
  localparam logic [7:0] BAUD_WRITE_MASK = 8'h9B;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int STAT_RX_LEVEL_BIT = 0;
  localparam int STAT_TIMER_LSB = 16;

  // ----------------------------------------------------------------
  // Timer periods per bit in each mode
  // ----------------------------------------------------------------
  localparam logic [6:0] PRESCALE_ASYNC_SLOW = 7'h40;
  localparam logic [6:0] PRESCALE_ASYNC_FAST = 7'h10;
  localparam logic [6:0] PRESCALE_SYNC = 7'h04;

  typedef struct packed {
    logic sync;
    logic wide;
    logic high_speed;
    logic [15:0] divisor;
  } sbg_rate_cfg_type;

  typedef struct packed {
    logic valid;
    logic last;
  } sbg_sample_type;

endpackage

// >>> hdl/sbg_majority.sv
// Three-sample majority vote of the receive line
`timescale 1ns/1ps
module sbg_majority (
  input wire logic pclk,
  input wire logic presetn,
  input wire sbg_pkg::sbg_sample_type sample,
  input wire logic rx_line,
  output logic rx_level,
  output logic rx_level_valid
);
  import sbg_pkg::*;

  logic [1:0] taken;
  logic [1:0] next_taken;
  logic next_rx_level;
  logic next_rx_level_valid;

  always_comb
  begin
    next_taken = taken;
    next_rx_level = rx_level;
    next_rx_level_valid = 1'b0;
    if (sample.valid)
    begin
      if (sample.last)
      begin
        // Two of three decide the level
        next_rx_level = (taken[0] & taken[1]) | (rx_line & (taken[0] | taken[1])); // see R03
        next_rx_level_valid = 1'b1;
      end
      next_taken = {taken[0], rx_line};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      taken <= 2'b11;
      rx_level <= 1'b1;
      rx_level_valid <= 1'b0;
    end
    else
    begin
      taken <= next_taken;
      rx_level <= next_rx_level;
      rx_level_valid <= next_rx_level_valid;
    end
  end

endmodule

// >>> hdl/sbg_baud_generator.sv
// Baud rate generator with APB register file and receive-line majority sampling
// Functional notes
// R01: Bit timing derives from the system clock.
// R02: Software reprograms divisor after clock change.
// R03: Three samples per bit, majority decides.
// R04: Async narrow slow: clock over 64(n+1).
// R05: Async one select set: clock over 16(n+1).
// R06: Sync: clock over 4(n+1), ignore speed.
// R07: Divisor is high byte concatenated low byte.
// R08: Async both selects: clock over 4(n+1).
// R09: Narrow by default; wide select enables 16-bit.
// R10: Divisor write clears the timer at once.
// R11: Divisor sets free-running timer period.
`timescale 1ns/1ps
module sbg_baud_generator #(
  parameter int DIV_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sbg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  output logic bit_tick,
  output logic sample_tick,
  output logic rx_level,
  output logic rx_level_valid,
  output sbg_pkg::sbg_rate_cfg_type rate_cfg
);
  import sbg_pkg::*;

  // ----------------------------------------------------------------
  // Decoding shared by read and write paths
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_TRANSMIT_STATUS_CONTROL) || (a == ADDR_RECEIVE_STATUS_CONTROL)
      || (a == ADDR_BAUD_CONTROL) || (a == ADDR_DIVISOR_HIGH_BYTE)
      || (a == ADDR_DIVISOR_LOW_BYTE) || (a == ADDR_GENERATOR_STATUS);
  endfunction

  // Timer periods per bit for a mode
  function automatic logic [6:0] prescale_len(input sbg_rate_cfg_type c);
    if (c.sync)
      prescale_len = PRESCALE_SYNC; // see R06
    else if (c.wide && c.high_speed)
      prescale_len = PRESCALE_SYNC; // see R08
    else if (c.wide || c.high_speed)
      prescale_len = PRESCALE_ASYNC_FAST; // see R05
    else
      prescale_len = PRESCALE_ASYNC_SLOW; // see R04
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] transmit_status_control;
  logic [7:0] receive_status_control;
  logic [7:0] baud_control;
  logic [7:0] divisor_high_byte;
  logic [7:0] divisor_low_byte;
  logic [7:0] next_transmit_status_control;
  logic [7:0] next_receive_status_control;
  logic [7:0] next_baud_control;
  logic [7:0] next_divisor_high_byte;
  logic [7:0] next_divisor_low_byte;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic wr_access;
  logic divisor_write;

  logic [DIV_W-1:0] timer;
  logic [DIV_W-1:0] next_timer;

  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite && addr_mapped(paddr);
  // A write to either byte restarts the count so the new rate shows at once
  assign divisor_write = wr_access
    && ((paddr == ADDR_DIVISOR_HIGH_BYTE) || (paddr == ADDR_DIVISOR_LOW_BYTE)); // see R10

  always_comb
  begin
    next_transmit_status_control = transmit_status_control;
    next_receive_status_control = receive_status_control;
    next_baud_control = baud_control;
    next_divisor_high_byte = divisor_high_byte;
    next_divisor_low_byte = divisor_low_byte;
    if (wr_access)
    begin
      case (paddr)
        ADDR_TRANSMIT_STATUS_CONTROL: next_transmit_status_control = pwdata[7:0];
        ADDR_RECEIVE_STATUS_CONTROL: next_receive_status_control = pwdata[7:0];
        ADDR_BAUD_CONTROL: next_baud_control = pwdata[7:0] & BAUD_WRITE_MASK;
        ADDR_DIVISOR_HIGH_BYTE: next_divisor_high_byte = pwdata[7:0];
        ADDR_DIVISOR_LOW_BYTE: next_divisor_low_byte = pwdata[7:0];
        default: next_divisor_low_byte = divisor_low_byte;
      endcase
    end
  end

  // Read data is captured in the setup cycle and stands through the access cycle
  always_comb
  begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        ADDR_TRANSMIT_STATUS_CONTROL: next_prdata[7:0] = transmit_status_control;
        ADDR_RECEIVE_STATUS_CONTROL: next_prdata[7:0] = receive_status_control;
        ADDR_BAUD_CONTROL: next_prdata[7:0] = baud_control;
        ADDR_DIVISOR_HIGH_BYTE: next_prdata[7:0] = divisor_high_byte;
        ADDR_DIVISOR_LOW_BYTE: next_prdata[7:0] = divisor_low_byte;
        ADDR_GENERATOR_STATUS:
        begin
          next_prdata[STAT_RX_LEVEL_BIT] = rx_level;
          next_prdata[STAT_TIMER_LSB +: DIV_W] = timer;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
      next_pslverr = !addr_mapped(paddr);
    end
    else if (psel && penable)
    begin
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transmit_status_control <= REG_RESET;
      receive_status_control <= REG_RESET;
      baud_control <= REG_RESET;
      divisor_high_byte <= REG_RESET;
      divisor_low_byte <= REG_RESET;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      transmit_status_control <= next_transmit_status_control;
      receive_status_control <= next_receive_status_control;
      baud_control <= next_baud_control;
      divisor_high_byte <= next_divisor_high_byte;
      divisor_low_byte <= next_divisor_low_byte;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Mode and divisor
  // ----------------------------------------------------------------
  sbg_rate_cfg_type cfg;
  logic [6:0] plen;
  logic [6:0] pmid;

  always_comb
  begin
    cfg.sync = transmit_status_control[TXSC_SYNC_BIT];
    cfg.high_speed = transmit_status_control[TXSC_HIGH_SPEED_BIT] && !cfg.sync; // see R06
    cfg.wide = baud_control[BAUD_WIDE_DIVISOR_BIT]; // see R09
    // The high byte is ignored in narrow mode
    if (cfg.wide)
      cfg.divisor = {divisor_high_byte, divisor_low_byte}; // see R07
    else
      cfg.divisor = {8'h00, divisor_low_byte}; // see R09
  end

  assign plen = prescale_len(cfg);
  assign pmid = {1'b0, plen[6:1]};

  // ----------------------------------------------------------------
  // Free-running timer and prescaler, both on the system clock
  // ----------------------------------------------------------------
  logic [6:0] pre;
  logic [6:0] next_pre;
  logic base_tick;
  logic next_bit_tick;
  sbg_sample_type next_sample;
  sbg_sample_type sample;

  // Wrap on >= so a shrunk divisor or mode change never strands the count
  assign base_tick = (timer >= cfg.divisor[DIV_W-1:0]); // see R11

  always_comb
  begin
    next_timer = timer;
    next_pre = pre;
    next_bit_tick = 1'b0;
    next_sample = '0;
    if (divisor_write)
    begin
      next_timer = '0; // see R10
      next_pre = 7'h00;
    end
    else if (base_tick)
    begin
      next_timer = '0; // see R11
      if (pre >= plen - 7'h01)
      begin
        next_pre = 7'h00;
        next_bit_tick = 1'b1; // see R01
      end
      else
        next_pre = pre + 7'h01;
      // Three samples straddle the middle of the bit
      next_sample.valid = (pre == pmid - 7'h01) || (pre == pmid) || (pre == pmid + 7'h01); // see R03
      next_sample.last = (pre == pmid + 7'h01);
    end
    else
      next_timer = timer + {{(DIV_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer <= '0;
      pre <= 7'h00;
      bit_tick <= 1'b0;
      sample <= '0;
      rate_cfg <= '0;
    end
    else
    begin
      timer <= next_timer;
      pre <= next_pre;
      bit_tick <= next_bit_tick;
      sample <= next_sample;
      rate_cfg <= cfg;
    end
  end

  assign sample_tick = sample.valid;

  // ----------------------------------------------------------------
  // Receive-line majority detect
  // ----------------------------------------------------------------
  sbg_majority u_majority (
    .pclk(pclk),
    .presetn(presetn),
    .sample(sample),
    .rx_line(rx_line),
    .rx_level(rx_level),
    .rx_level_valid(rx_level_valid)
  );

endmodule

// >>> bench/sbg_baud_generator_checker.sv
// Checker: port-level properties of the baud generator
`timescale 1ns/1ps
module sbg_baud_generator_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_tick,
  input wire logic sample_tick,
  input wire logic rx_level_valid,
  input wire sbg_pkg::sbg_rate_cfg_type rate_cfg
);
  import sbg_pkg::*;
  logic acc;
  logic dwr;
  assign acc = psel && penable;
  assign dwr = acc && pwrite && (paddr == ADDR_DIVISOR_HIGH_BYTE || paddr == ADDR_DIVISOR_LOW_BYTE);
  logic mwr;
  logic settled;
  logic [2:0] samples;
  assign mwr = acc && pwrite
    && (paddr == ADDR_TRANSMIT_STATUS_CONTROL || paddr == ADDR_BAUD_CONTROL);
  // A mode change mid-bit may skip or repeat samples, so count only after a clean restart
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      settled <= 1'b0;
      samples <= 3'h0;
    end
    else
    begin
      if (dwr)
        settled <= 1'b1;
      else if (mwr)
        settled <= 1'b0;
      if (dwr || bit_tick)
        samples <= 3'h0;
      else if (sample_tick && samples != 3'h7)
        samples <= samples + 3'h1;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00))
    else $error("pslverr wrong");
  a_err_zero_data: assert property (acc && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read data not zero");
  a_sync_no_speed: assert property (rate_cfg.sync |-> !rate_cfg.high_speed)
    else $error("speed select active in sync");
  a_narrow_high_zero: assert property (!rate_cfg.wide |-> rate_cfg.divisor[15:8] == 8'h00)
    else $error("high byte used when narrow");
  // The write cycle already blocks the tick of the next cycle; this looks at the second and third cycles after it
  a_clear_on_write: assert property (dwr |=> ##1 !bit_tick [*2])
    else $error("tick too soon after divisor write");
  a_tick_single: assert property (bit_tick |=> !bit_tick)
    else $error("tick longer than one cycle");
  a_tick_sampled: assert property (settled && bit_tick |-> samples + {2'b00, sample_tick} == 3'h3)
    else $error("bit period without exactly three samples");
  a_valid_follows: assert property (rx_level_valid |-> $past(sample_tick))
    else $error("vote not one cycle after tick");
  c_tick: cover property (bit_tick);
  c_vote: cover property (rx_level_valid);
  c_refuse: cover property (acc && pslverr);
  c_fast: cover property (bit_tick && rate_cfg.wide && rate_cfg.high_speed);
endmodule

bind sbg_baud_generator sbg_baud_generator_checker u_sbg_baud_generator_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_tick(bit_tick),
  .sample_tick(sample_tick), .rx_level_valid(rx_level_valid), .rate_cfg(rate_cfg));

// >>> bench/sbg_rx_node.sv
// Remote serial node: new random bit on each tick, with a one-cycle glitch inside it
`timescale 1ns/1ps
module sbg_rx_node (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_tick,
  input wire logic sample_tick,
  output logic rx_line,
  output logic held_bit
);
  logic [31:0] s;
  logic [1:0] age;
  logic cur;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s <= 32'h0001_4238;
      cur <= 1'b1;
      age <= 2'h3;
    end
    else if (bit_tick)
    begin
      cur <= s[0];
      s <= {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      age <= 2'h0;
    end
    else if (age != 2'h3)
      age <= age + 2'h1;
  // The vote must match the clean level that stood while the samples were taken
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      held_bit <= 1'b1;
    else if (sample_tick)
      held_bit <= cur;
  // A single bad cycle can spoil one sample only
  assign rx_line = cur ^ (age == 2'h1);
endmodule

// >>> bench/sbg_baud_generator_tb_top.sv
// Testbench: registers, rate per mode, timer clear and voted receive level
`timescale 1ns/1ps
module sbg_baud_generator_tb_top;
  import sbg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic bit_tick, sample_tick, rx_level, rx_level_valid, rx_line, held_bit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  sbg_rate_cfg_type rate_cfg;
  int error_cnt, checks;
  sbg_baud_generator u_sbg_baud_generator (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .bit_tick(bit_tick),
    .sample_tick(sample_tick), .rx_level(rx_level), .rx_level_valid(rx_level_valid),
    .rate_cfg(rate_cfg));
  sbg_rx_node u_sbg_rx_node (.pclk(pclk), .presetn(presetn), .bit_tick(bit_tick),
    .sample_tick(sample_tick), .rx_line(rx_line), .held_bit(held_bit));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // m is {sync, wide, high_speed}
  function automatic int per(input logic [2:0] m, input logic [15:0] n);
    int p;
    p = (m[2] || (m[1] && m[0])) ? 4 : (m[1] || m[0]) ? 16 : 64;
    return p * (int'(n) + 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic meas(input logic [2:0] m, input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] n;
    int c;
    n = m[1] ? {hi, lo} : {8'h00, lo};
    apb(1'b1, ADDR_TRANSMIT_STATUS_CONTROL, {27'h0, m[2], 1'b0, m[0], 2'b00});
    apb(1'b1, ADDR_BAUD_CONTROL, {28'h0, m[1], 3'b000});
    apb(1'b1, ADDR_DIVISOR_HIGH_BYTE, {24'h0, hi});
    apb(1'b1, ADDR_DIVISOR_LOW_BYTE, {24'h0, lo});
    c = 0;
    do begin @(posedge pclk); c++; end while (bit_tick !== 1'b1);
    chk("first tick in window", 1, c >= per(m, n) && c <= per(m, n) + 2);
    chk("rate cfg", {13'h0, m[2], m[1], m[0] & ~m[2], n}, rate_cfg);
    c = 0;
    do begin @(posedge pclk); c++; end while (bit_tick !== 1'b1);
    chk("bit period", per(m, n), c);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk)
    if (presetn && rx_level_valid === 1'b1)
      chk("voted level", held_bit, rx_level);
  initial
  begin
    repeat (90000) @(posedge pclk);
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    seed = 32'h0001_4238;
    error_cnt = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 20; a += 4)
    begin
      apb(1'b0, a[7:0], 32'h0000_0000);
      chk("reset value", {24'h0, REG_RESET}, rd);
    end
    // Divisor zero keeps the timer at zero; the line is idle high so far
    apb(1'b0, ADDR_GENERATOR_STATUS, 32'h0000_0000);
    chk("status after reset", 32'h0000_0001, rd);
    apb(1'b1, ADDR_BAUD_CONTROL, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_BAUD_CONTROL, 32'h0000_0000);
    chk("baud control mask", {24'h0, BAUD_WRITE_MASK}, rd);
    seed = lfsr(seed);
    apb(1'b1, ADDR_RECEIVE_STATUS_CONTROL, seed);
    apb(1'b0, ADDR_RECEIVE_STATUS_CONTROL, 32'h0000_0000);
    chk("receive control", {24'h0, seed[7:0]}, rd);
    apb(1'b1, 8'h18, seed);
    chk("write refused", 1, er);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("read refused", 1, er);
    chk("refused data", 0, rd);
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 8; m++)
      begin
        seed = lfsr(seed);
        meas(m[2:0], m[1] ? {7'h0, seed[8]} : seed[15:8], r == 0 ? 8'h00 : {4'h0, seed[3:0]});
      end
    wrap_up;
  end
endmodule
